/* dib_pkg.sv */
// Purpose: constants and types for the input-path signature block
// Assumes: byte-wide registers on a four-wire serial port (separate sdi and sdo), five-bit address
// Notes: offsets are the register addresses seen on the serial port
package dib_pkg;
   // register addresses
   localparam logic [4:0] DIB_ADDR_CTRL = 5'h11; // self_test_control
   localparam logic [4:0] DIB_ADDR_SIG0 = 5'h12; // signature_byte0, bits 7:0
   localparam logic [4:0] DIB_ADDR_SIG1 = 5'h13; // signature_byte1, bits 15:8
   localparam logic [4:0] DIB_ADDR_SIG2 = 5'h14; // signature_byte2, bits 23:16
   localparam logic [4:0] DIB_ADDR_SIG3 = 5'h15; // signature_byte3, bits 31:24
   localparam logic [7:0] DIB_CTRL_RESET = 8'h00; // control reset value
   // control field positions
   localparam int DIB_BIT_CLEAR = 0; // clear all signatures
   localparam int DIB_BIT_FIFO_EN = 1; // enable fifo-stage compressors
   localparam int DIB_BIT_INPUT_EN = 2; // enable input-stage compressors
   localparam int DIB_BIT_SIGNATURE_READ_ENABLE = 5; // signature_read_enable
   localparam int DIB_SEL_HI = 7; // select field top bit
   localparam int DIB_SEL_LO = 6; // select field bottom bit
   // serial command layout
   localparam int DIB_CMD_RW_BIT = 7; // 1 = read
   // widths
   localparam int DIB_DATA_W = 14; // sample_data_bus width
   localparam int DIB_SIG_W = 32; // compressor width
   localparam int DIB_XNOR_TOP = 13; // last bit that mixes in data
   // timing seen by the far side, in data-clock cycles
   localparam int DIB_CLEAR_HOLD_DCLK = 50;
   localparam int DIB_RESET_PHASE_DCLK = 16;
   // serial state machine, gray along the usual path
   typedef enum logic [1:0] {
      DIB_SPI_IDLE = 2'b00,
      DIB_SPI_CMD = 2'b01,
      DIB_SPI_DATA = 2'b11,
      DIB_SPI_DONE = 2'b10
   } dib_spi_state_type;
endpackage : dib_pkg

/* dib_signature.sv */
// Purpose: signature compressors on the sample input path with serial register access
// Assumes: clock is the conversion clock; pins are asynchronous and synchronised here
// Notes: the source centres its data clock edges in the data eye
`timescale 1ns/1ps
module dib_signature
   import dib_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic source_data_clock, // ddr data clock pin
   input wire logic [DIB_DATA_W-1:0] sample_data_bus, // ddr sample pins
   input wire logic reset_pin, // device reset pin, active high
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe
);

   // one compressor step; the zero word is skipped
   function automatic logic [DIB_SIG_W-1:0] lfsr_step(input logic [DIB_SIG_W-1:0] s,
                                                      input logic [DIB_DATA_W-1:0] d);
      logic [DIB_SIG_W-1:0] n;
      n = s;
      if (d != '0) begin
         n = {s[DIB_SIG_W-2:0], 1'b0};
         n[0] = ~(s[DIB_SIG_W-1] ^ d[0]);
         for (int i = 1; i <= DIB_XNOR_TOP; i++) begin
            n[i] = ~(s[i-1] ^ d[i]);
         end
      end
      return n;
   endfunction : lfsr_step

   // register read decode, shared by the shifter and a check
   function automatic logic [7:0] read_byte(input logic [4:0] a, input logic [7:0] c,
                                            input logic [DIB_SIG_W-1:0] s);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         DIB_ADDR_CTRL: r = c;
         DIB_ADDR_SIG0: r = c[DIB_BIT_SIGNATURE_READ_ENABLE] ? s[7:0] : 8'h00;
         DIB_ADDR_SIG1: r = c[DIB_BIT_SIGNATURE_READ_ENABLE] ? s[15:8] : 8'h00;
         DIB_ADDR_SIG2: r = c[DIB_BIT_SIGNATURE_READ_ENABLE] ? s[23:16] : 8'h00;
         DIB_ADDR_SIG3: r = c[DIB_BIT_SIGNATURE_READ_ENABLE] ? s[31:24] : 8'h00;
         default: r = 8'h00;
      endcase
      return r;
   endfunction : read_byte

   // pin synchronisers; only the second stage and the edge stages feed logic
   logic dclk_s1_reg, dclk_s2_reg, dclk_s3_reg;
   logic [DIB_DATA_W-1:0] data_s1_reg, data_s2_reg;
   logic rstp_s1_reg, rstp_s2_reg;
   logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
   logic cs_s1_reg, cs_s2_reg;
   logic sdi_s1_reg, sdi_s2_reg;

   // two flops, then an edge stage on the two clock pins only; no reset, so the edge stage tracks its pin
   always_ff @(posedge clock) begin
      dclk_s1_reg <= source_data_clock;
      dclk_s2_reg <= dclk_s1_reg;
      dclk_s3_reg <= dclk_s2_reg;
      data_s1_reg <= sample_data_bus;
      data_s2_reg <= data_s1_reg;
      rstp_s1_reg <= reset_pin;
      rstp_s2_reg <= rstp_s1_reg;
      sclk_s1_reg <= spi_sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg <= spi_cs_n;
      cs_s2_reg <= cs_s1_reg;
      sdi_s1_reg <= spi_sdi;
      sdi_s2_reg <= sdi_s1_reg;
   end

   logic dclk_rise, dclk_fall, sclk_rise, sclk_fall;
   assign dclk_rise = dclk_s2_reg & ~dclk_s3_reg;
   assign dclk_fall = ~dclk_s2_reg & dclk_s3_reg;
   assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
   assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;

   // ---------------- serial register port ----------------
   dib_spi_state_type spi_state_reg, spi_state_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next; // bit within the current byte
   logic [7:0] cmd_reg, cmd_next; // instruction byte; write data shifts into wdata_reg
   logic [7:0] wdata_reg, wdata_next;
   logic [7:0] out_shift_reg, out_shift_next; // read data, msb first
   logic [7:0] ctrl_reg, ctrl_next; // self_test_control
   logic sdo_reg, sdo_next;
   logic sdo_oe_reg, sdo_oe_next;
   logic wr_commit; // write of a full data byte
   logic [DIB_SIG_W-1:0] sig_reg [4]; // 0,1 input stage; 2,3 fifo stage
   logic [DIB_SIG_W-1:0] sel_sig;

   assign sel_sig = sig_reg[ctrl_reg[DIB_SEL_HI:DIB_SEL_LO]];

   // serial next state: command byte then one data byte
   always_comb begin
      spi_state_next = spi_state_reg;
      bit_cnt_next = bit_cnt_reg;
      cmd_next = cmd_reg;
      wdata_next = wdata_reg;
      out_shift_next = out_shift_reg;
      ctrl_next = ctrl_reg;
      sdo_next = sdo_reg;
      sdo_oe_next = 1'b0;
      wr_commit = 1'b0;
      if (cs_s2_reg) begin
         // deselect aborts any partial byte
         spi_state_next = DIB_SPI_IDLE;
         bit_cnt_next = 3'h0;
      end else begin
         case (spi_state_reg)
            DIB_SPI_IDLE: begin
               spi_state_next = DIB_SPI_CMD;
               bit_cnt_next = 3'h0;
            end
            DIB_SPI_CMD: begin
               if (sclk_rise) begin
                  cmd_next = {cmd_reg[6:0], sdi_s2_reg};
                  bit_cnt_next = bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7) begin
                     spi_state_next = DIB_SPI_DATA;
                     // read decode has no side effect
                     out_shift_next = read_byte(cmd_next[4:0], ctrl_reg, sel_sig);
                  end
               end
            end
            DIB_SPI_DATA: begin
               sdo_oe_next = cmd_reg[DIB_CMD_RW_BIT];
               if (sclk_fall) begin
                  sdo_next = out_shift_reg[7];
                  out_shift_next = {out_shift_reg[6:0], 1'b0};
               end
               if (sclk_rise) begin
                  wdata_next = {wdata_reg[6:0], sdi_s2_reg};
                  bit_cnt_next = bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7) begin
                     spi_state_next = DIB_SPI_DONE;
                     wr_commit = ~cmd_reg[DIB_CMD_RW_BIT];
                     if (wr_commit && cmd_reg[4:0] == DIB_ADDR_CTRL) begin
                        ctrl_next = wdata_next;
                     end
                  end
               end
            end
            DIB_SPI_DONE: begin
               // extra clocks until deselect are ignored
               sdo_oe_next = 1'b0;
            end
            default: spi_state_next = DIB_SPI_IDLE;
         endcase
      end
   end

   // serial registers
   always_ff @(posedge clock) begin
      if (srst) begin
         spi_state_reg <= DIB_SPI_IDLE;
         bit_cnt_reg <= 3'h0;
         cmd_reg <= 8'h00;
         wdata_reg <= 8'h00;
         out_shift_reg <= 8'h00;
         ctrl_reg <= DIB_CTRL_RESET;
         sdo_reg <= 1'b0;
         sdo_oe_reg <= 1'b0;
      end else begin
         spi_state_reg <= spi_state_next;
         bit_cnt_reg <= bit_cnt_next;
         cmd_reg <= cmd_next;
         wdata_reg <= wdata_next;
         out_shift_reg <= out_shift_next;
         ctrl_reg <= ctrl_next;
         sdo_reg <= sdo_next;
         sdo_oe_reg <= sdo_oe_next;
      end
   end

   assign spi_sdo = sdo_reg;
   assign spi_sdo_oe = sdo_oe_reg;
   // ---------------- sample datapath ----------------
   logic cap_vld_reg, cap_vld_next; // capture stage after receiver
   logic cap_ph_reg, cap_ph_next; // 0 rising, 1 falling
   logic [DIB_DATA_W-1:0] cap_data_reg, cap_data_next;
   logic fifo_vld_reg, fifo_vld_next; // stage after clock-domain fifo
   logic fifo_ph_reg, fifo_ph_next;
   logic [DIB_DATA_W-1:0] fifo_data_reg, fifo_data_next;
   logic [DIB_SIG_W-1:0] sig_next [4];
   logic clr;
   assign clr = ctrl_reg[DIB_BIT_CLEAR] | rstp_s2_reg;

   // datapath next values; the fifo is one fixed stage, so single rate matches
   always_comb begin
      cap_vld_next = dclk_rise | dclk_fall;
      cap_ph_next = dclk_fall;
      cap_data_next = (dclk_rise | dclk_fall) ? data_s2_reg : cap_data_reg;
      fifo_vld_next = cap_vld_reg;
      fifo_ph_next = cap_ph_reg;
      fifo_data_next = cap_data_reg;
      for (int g = 0; g < 4; g++) sig_next[g] = sig_reg[g];
      if (cap_vld_reg && ctrl_reg[DIB_BIT_INPUT_EN]) begin
         sig_next[{1'b0, cap_ph_reg}] = lfsr_step(sig_reg[{1'b0, cap_ph_reg}], cap_data_reg);
      end
      if (fifo_vld_reg && ctrl_reg[DIB_BIT_FIFO_EN]) begin
         sig_next[{1'b1, fifo_ph_reg}] = lfsr_step(sig_reg[{1'b1, fifo_ph_reg}], fifo_data_reg);
      end
      if (clr) begin
         for (int g = 0; g < 4; g++) sig_next[g] = '0;
      end
   end

   // datapath registers; reset pin also empties the stages
   always_ff @(posedge clock) begin
      if (srst || rstp_s2_reg) begin
         cap_vld_reg <= 1'b0;
         cap_ph_reg <= 1'b0;
         cap_data_reg <= '0;
         fifo_vld_reg <= 1'b0;
         fifo_ph_reg <= 1'b0;
         fifo_data_reg <= '0;
         for (int g = 0; g < 4; g++) sig_reg[g] <= '0;
      end else begin
         cap_vld_reg <= cap_vld_next;
         cap_ph_reg <= cap_ph_next;
         cap_data_reg <= cap_data_next;
         fifo_vld_reg <= fifo_vld_next;
         fifo_ph_reg <= fifo_ph_next;
         fifo_data_reg <= fifo_data_next;
         for (int g = 0; g < 4; g++) sig_reg[g] <= sig_next[g];
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst || rstp_s2_reg);
   sequence rise_seen_s;
      dclk_rise;
   endsequence
   sequence cap_ph1_s;
      cap_vld_reg && !cap_ph_reg;
   endsequence
   ph1_capture_a: assert property (rise_seen_s |=> cap_ph1_s)
      else $error("rising data edge not captured as phase 1");
   ph2_capture_a: assert property (dclk_fall |=> cap_vld_reg && cap_ph_reg
                                   && cap_data_reg == $past(data_s2_reg))
      else $error("falling data edge not captured as phase 2");
   lfsr_step_a: assert property (cap_ph1_s and (ctrl_reg[DIB_BIT_INPUT_EN] && !clr)
         |=> sig_reg[0] == lfsr_step($past(sig_reg[0]), $past(cap_data_reg)))
      else $error("phase 1 input signature step wrong");
   zero_hold_a: assert property (cap_vld_reg && cap_data_reg == '0 && !clr && !fifo_vld_reg
         |=> $stable(sig_reg[0]) && $stable(sig_reg[1]))
      else $error("idle word changed an input signature");
   clear_zero_a: assert property (ctrl_reg[DIB_BIT_CLEAR] |=> sig_reg[0] == '0
         && sig_reg[1] == '0 && sig_reg[2] == '0 && sig_reg[3] == '0)
      else $error("clear did not zero signatures");
   fifo_off_a: assert property (!ctrl_reg[DIB_BIT_FIFO_EN] && !clr
         |=> $stable(sig_reg[2]) && $stable(sig_reg[3]))
      else $error("disabled fifo stage signature moved");
   fifo_follow_a: assert property (cap_vld_reg ##1 fifo_vld_reg
         |-> fifo_data_reg == $past(cap_data_reg) && fifo_ph_reg == $past(cap_ph_reg))
      else $error("fifo stage saw a different word");
   ctrl_only_a: assert property (ctrl_reg != $past(ctrl_reg)
         |-> $past(wr_commit) && $past(cmd_reg[4:0]) == DIB_ADDR_CTRL)
      else $error("control changed without a control write");
   read_top_a: assert property (spi_state_reg == DIB_SPI_CMD && sclk_rise && bit_cnt_reg == 3'h7
         && !cs_s2_reg |=> out_shift_reg == read_byte(cmd_reg[4:0], ctrl_reg, sel_sig)
         || $changed(sel_sig))
      else $error("read byte not loaded from decode");
endmodule : dib_signature

/* dib_src_model.sv */
// Purpose: sample source model, drives ddr words and the data clock
// Assumes: each word changes midway between two data clock edges
// Notes: the data clock stands still low between bursts
`timescale 1ns/1ps
module dib_src_model
   import dib_pkg::*;
(
   output logic source_data_clock, // ddr data clock to the block
   output logic [DIB_DATA_W-1:0] sample_data_bus // ddr words to the block
);
   // unsigned idle word keeps the signatures still
   localparam logic [DIB_DATA_W-1:0] IDLE_WORD = 14'h0000;
   // start quiet, clock low and idle word on the bus
   initial begin
      source_data_clock = 1'b0;
      sample_data_bus = IDLE_WORD;
   end
   // n words, then idle for idle_cyc full data clock cycles
   task automatic send(input logic [DIB_DATA_W-1:0] w [8], input int n, input int idle_cyc);
      for (int h = 0; h < n + 2 * idle_cyc; h++) begin
         sample_data_bus = (h < n) ? w[h] : IDLE_WORD;
         // centring the edge leaves a wide eye for the synchronisers
         #50;
         source_data_clock = ~source_data_clock;
         #50;
      end
   endtask : send
endmodule : dib_src_model

/* dib_tb.sv */
// Purpose: self-checking bench for the signature block
// Assumes: serial clock idles low, each level 150 ns
// Notes: expected signatures are computed here from the word lists
`timescale 1ns/1ps
module testbench
   import dib_pkg::*;
();
   logic clock; // 40 MHz
   logic srst;
   logic source_data_clock;
   logic [DIB_DATA_W-1:0] sample_data_bus;
   logic reset_pin;
   logic spi_sclk;
   logic spi_cs_n;
   logic spi_sdi;
   logic spi_sdo;
   logic spi_sdo_oe;
   int n_mismatch = 0; // failed compares
   int n_checks = 0; // all compares
   int cycles = 0; // hang guard
   logic [DIB_DATA_W-1:0] vec_a [8]; // first vector, holds a zero word
   logic [DIB_DATA_W-1:0] vec_b [8]; // second vector
   logic [31:0] p1; // expected phase 1
   logic [31:0] p2; // expected phase 2
   logic [31:0] q1;
   logic [31:0] q2;
   dib_signature DUT (.clock(clock), .srst(srst), .source_data_clock(source_data_clock),
      .sample_data_bus(sample_data_bus), .reset_pin(reset_pin), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
   dib_src_model src (.source_data_clock(source_data_clock), .sample_data_bus(sample_data_bus));
   // 25 ns clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // hang guard, well above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         test_done();
      end
   end
   // inputs move 1 ns after the rising edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_clk
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one frame: command byte then data byte, read bits taken late in each low phase
   task automatic spi(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      rd = 8'h00;
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_sdi = sh[i];
         wait_clk(6);
         if (i < 8) rd[i] = spi_sdo;
         if (cmd[DIB_CMD_RW_BIT] && i == 7) check(32'(spi_sdo_oe), 32'h1);
         spi_sclk = 1'b1;
         wait_clk(6);
         spi_sclk = 1'b0;
      end
      wait_clk(6);
      spi_cs_n = 1'b1;
      // gap covers the chip-select synchroniser
      wait_clk(8);
   endtask : spi
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] r;
      spi({3'b000, a}, d, r);
   endtask : wr
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] r;
      spi({3'b100, a}, 8'h00, r);
      check(32'(r), 32'(exp));
   endtask : rd_chk
   // select one generator, then read its bytes most significant first
   task automatic chk_sel(input logic [1:0] sel, input logic [31:0] exp);
      wr(DIB_ADDR_CTRL, {sel, 6'h26});
      rd_chk(DIB_ADDR_CTRL, {sel, 6'h26});
      rd_chk(DIB_ADDR_SIG3, exp[31:24]);
      rd_chk(DIB_ADDR_SIG2, exp[23:16]);
      rd_chk(DIB_ADDR_SIG1, exp[15:8]);
      rd_chk(DIB_ADDR_SIG0, exp[7:0]);
   endtask : chk_sel
   task automatic chk_all(input logic [31:0] i1, i2, f1, f2);
      chk_sel(2'b00, i1);
      chk_sel(2'b01, i2);
      chk_sel(2'b10, f1);
      chk_sel(2'b11, f2);
   endtask : chk_all
   function automatic logic [31:0] step(input logic [31:0] s, input logic [13:0] d);
      if (d == 14'h0000) return s;
      return {s[30:13], ~(s[12:0] ^ d[13:1]), ~(s[31] ^ d[0])};
   endfunction : step
   // send a burst and fold it into the expected pair
   task automatic run(input logic [13:0] w [8], input int n, inout logic [31:0] a, b);
      src.send(w, n, 4);
      wait_clk(1);
      for (int h = 0; h < n; h++) begin
         // even index is a rising sample
         if (h % 2 == 0) a = step(a, w[h]);
         else b = step(b, w[h]);
      end
   endtask : run
   // main sequence
   initial begin
      srst = 1'b1;
      reset_pin = 1'b0;
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
      vec_a = '{14'h1ABC, 14'h2001, 14'h0000, 14'h3FFF, 14'h0155, 14'h2AAA, 14'h0, 14'h0};
      vec_b = '{14'h0F0F, 14'h1234, 14'h3001, 14'h0000, 14'h0, 14'h0, 14'h0, 14'h0};
      wait_clk(8);
      srst = 1'b0;
      wait_clk(4);
      rd_chk(DIB_ADDR_CTRL, DIB_CTRL_RESET);
      rd_chk(5'h1F, 8'h00);
      $display("test reset done");
      // reset pin twice, idle data running
      for (int k = 0; k < 2; k++) begin
         reset_pin = 1'b1;
         src.send(vec_a, 0, 16);
         wait_clk(1);
         reset_pin = 1'b0;
         src.send(vec_a, 0, 16);
         wait_clk(1);
      end
      // flush pass, then the clean clear
      for (int k = 0; k < 2; k++) begin
         wr(DIB_ADDR_CTRL, 8'h07);
         src.send(vec_a, 0, 50);
         wait_clk(1);
         wr(DIB_ADDR_CTRL, 8'h06);
      end
      chk_all(32'h0, 32'h0, 32'h0, 32'h0);
      $display("test clear done");
      p1 = 32'h0;
      p2 = 32'h0;
      run(vec_a, 6, p1, p2);
      chk_all(p1, p2, p1, p2);
      $display("test vector done");
      // control changes while idle words keep arriving
      fork
         src.send(vec_a, 0, 30);
         wr(DIB_ADDR_CTRL, 8'h26);
      join
      wait_clk(1);
      wr(DIB_ADDR_SIG0, 8'h5A);
      wr(DIB_ADDR_SIG3, 8'hA5);
      chk_all(p1, p2, p1, p2);
      $display("test idle config done");
      // fifo stage off: only the input pair moves
      wr(DIB_ADDR_CTRL, 8'h24);
      q1 = p1;
      q2 = p2;
      run(vec_b, 4, q1, q2);
      chk_all(q1, q2, p1, p2);
      $display("test enable done");
      // read enable low gates the byte registers to zero
      wr(DIB_ADDR_CTRL, 8'h06);
      rd_chk(DIB_ADDR_SIG0, 8'h00);
      $display("test read gate done");
      test_done();
   end
endmodule : testbench
